// ---- hw/wkr_pkg.sv ----
// wakeup receiver configuration bank: types, addresses, reset values, timing
// Behaviour
// - channel enable bits power channels; reset on
// - regulator bit: on or bypass; reset on
// - rotation bits pick mode or short; reset 0
// - antenna to channel routing follows rotation mode
// - indicator select: channel, bandgap or wake
// - output mode: hiz, analog, digital, unused
// - chip select low forces indicator hiz
// - damping bit connects input resistors; reset 0
// - channel wake, reset or generator asserts wake
// - release bit holds wake high, rearm after
// - test enable picks wake pin source
// - test select routes channel data or wake
// - step bit selects indicator step; reset 1
// - generator raises wake every two hours
// - 8-bit lsb-first frame latched on select fall
// - reset restores defaults, wake low after reset
package wkr_pkg;

  // register addresses carried in the two low frame bits
  localparam logic [1:0] WKR_ADDR_POWER     = 2'h0;
  localparam logic [1:0] WKR_ADDR_INDICATOR = 2'h1;
  localparam logic [1:0] WKR_ADDR_TEST      = 2'h2;
  localparam logic [1:0] WKR_ADDR_CORR      = 2'h3;

  // frame layout
  localparam int WKR_FRAME_W  = 8;
  localparam int WKR_DATA_LSB = 2;
  localparam int WKR_CHANNELS = 3;

  typedef struct packed {
    logic rotation_sel_hi;
    logic rotation_sel_lo;
    logic regulator_on;
    logic chan3_on;
    logic chan2_on;
    logic chan1_on;
  } wkr_power_t;

  typedef struct packed {
    logic wake_release;
    logic input_damping_on;
    logic indicator_mode_hi;
    logic indicator_mode_lo;
    logic indicator_sel_hi;
    logic indicator_sel_lo;
  } wkr_indicator_t;

  typedef struct packed {
    logic periodic_wake_on;
    logic indicator_step_high;
    logic test_spare;
    logic test_sel_hi;
    logic test_sel_lo;
    logic test_enable_bit;
  } wkr_test_t;

  // values after reset
  localparam wkr_power_t     WKR_POWER_RST     = 6'h0F;
  localparam wkr_indicator_t WKR_INDICATOR_RST = 6'h00;
  localparam wkr_test_t      WKR_TEST_RST      = 6'h10;

  // codes are {hi, lo}
  typedef enum logic [1:0] {
    WKR_ROT_MODE1 = 2'b00,
    WKR_ROT_MODE2 = 2'b01,
    WKR_ROT_MODE3 = 2'b10,
    WKR_ROT_SHORT = 2'b11
  } wkr_rot_t;

  typedef enum logic [1:0] {
    WKR_OUT_HIZ     = 2'b00,
    WKR_OUT_ANALOG  = 2'b01,
    WKR_OUT_DIGITAL = 2'b10,
    WKR_OUT_UNUSED  = 2'b11
  } wkr_outmode_t;

  typedef enum logic [1:0] {
    WKR_TST_DATA   = 2'b00,
    WKR_TST_CHWAKE = 2'b01
  } wkr_tstsel_t;

  localparam logic [1:0] WKR_SEL_SPECIAL = 2'h3;

  // wake generator period
  localparam longint WKR_CLK_HZ       = 25000000;
  localparam longint WKR_GEN_PERIOD_S = 7200;  // two hours
  localparam longint WKR_GEN_CYCLES   = WKR_GEN_PERIOD_S * WKR_CLK_HZ;
  localparam int     WKR_GEN_CNT_W    = 38;

  // link side state: shift register clocked by the serial clock
  typedef struct packed {
    logic [WKR_FRAME_W-1:0] shift;
  } wkr_link_t;

  // core side state
  typedef struct packed {
    logic                     cs_s1;
    logic                     cs_s2;
    logic                     cs_s3;
    logic [2:0]               wk_s1;
    logic [2:0]               wk_s2;
    logic [2:0]               dt_s1;
    logic [2:0]               dt_s2;
    wkr_power_t               pwr;
    wkr_indicator_t           ind;
    wkr_test_t                tst;
    logic                     wake_act;
    logic                     por_pend;
    logic [WKR_GEN_CNT_W-1:0] gen_cnt;
  } wkr_core_t;

endpackage

// ---- hw/wkr_cfg_regs.sv ----
// wakeup receiver configuration registers, serial loader and wake output logic
`timescale 1ns/1ps
module wkr_cfg_regs
#(
  parameter logic [wkr_pkg::WKR_GEN_CNT_W-1:0] P_GEN_CYCLES = wkr_pkg::WKR_GEN_CNT_W'(wkr_pkg::WKR_GEN_CYCLES)
)
(
  // core clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  // serial programming link
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  input  wire logic       I_CS,
  // receive chain status
  input  wire logic [2:0] I_CH_WAKE,
  input  wire logic [2:0] I_CH_DATA,
  // analog controls
  output logic      [2:0] O_CHAN_ON,
  output logic            O_REG_ON,
  output logic      [5:0] O_ANT_SEL,
  output logic            O_INPUT_SHORT,
  output logic            O_DAMP_ON,
  output logic            O_STEP_HIGH,
  // indicator pin
  output logic      [1:0] O_IND_SEL,
  output logic            O_BANDGAP_SEL,
  output logic            O_IND_ANALOG_EN,
  output logic            O_IND_O,
  output logic            O_IND_OE,
  // wake pin
  output logic            O_WAKE_N
);
  import wkr_pkg::*;

  wkr_link_t lr;
  wkr_link_t ln;
  wkr_core_t r;
  wkr_core_t n;

  logic                     cs_fall;
  logic [1:0]               frame_addr;
  logic [5:0]               frame_data;
  logic                     gen_hit;
  logic [1:0]               sel;
  logic                     sel_data;
  logic                     sel_wake;
  logic                     wake_pin_n;
  wkr_rot_t                 rot;
  wkr_outmode_t             omode;
  wkr_tstsel_t              tsel;

  // link domain: shift lsb-first while selected; no edges arrive outside a frame
  always_comb
  begin
    ln = lr;
    if (I_CS)
    begin
      ln.shift = {I_SDA, lr.shift[WKR_FRAME_W-1:1]};
    end
  end

  always_ff @(posedge I_SCL)
  begin
    lr <= ln;
  end

  // the shift register is quiet once select falls, so the core samples it directly
  assign cs_fall    = r.cs_s3 & ~r.cs_s2;
  assign frame_addr = lr.shift[1:0];
  assign frame_data = lr.shift[WKR_FRAME_W-1:WKR_DATA_LSB];

  // generator fires on the last count of its period
  assign gen_hit = r.tst.periodic_wake_on && (r.gen_cnt == P_GEN_CYCLES - 1'b1);

  assign rot   = wkr_rot_t'({r.pwr.rotation_sel_hi, r.pwr.rotation_sel_lo});
  assign omode = wkr_outmode_t'({r.ind.indicator_mode_hi, r.ind.indicator_mode_lo});
  assign tsel  = wkr_tstsel_t'({r.tst.test_sel_hi, r.tst.test_sel_lo});
  assign sel   = {r.ind.indicator_sel_hi, r.ind.indicator_sel_lo};

  // core next state
  always_comb
  begin
    n       = r;
    n.cs_s1 = I_CS;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.wk_s1 = I_CH_WAKE;
    n.wk_s2 = r.wk_s1;
    n.dt_s1 = I_CH_DATA;
    n.dt_s2 = r.dt_s1;
    // frame latched on the falling edge of select
    if (cs_fall)
    begin
      if (frame_addr == WKR_ADDR_POWER)
      begin
        n.pwr = wkr_power_t'(frame_data);
      end
      else if (frame_addr == WKR_ADDR_INDICATOR)
      begin
        n.ind = wkr_indicator_t'(frame_data);
      end
      else if (frame_addr == WKR_ADDR_TEST)
      begin
        n.tst = wkr_test_t'(frame_data);
      end
    end
    // counter held clear while the generator is off
    if (!r.tst.periodic_wake_on || gen_hit)
    begin
      n.gen_cnt = '0;
    end
    else
    begin
      n.gen_cnt = r.gen_cnt + 1'b1;
    end
    // release holds wake off; events are ignored until it is written back to 0
    n.por_pend = 1'b0;
    if (r.ind.wake_release)
    begin
      n.wake_act = 1'b0;
    end
    else if (r.por_pend || (|r.wk_s2) || gen_hit)
    begin
      n.wake_act = 1'b1;
    end
    // defaults after reset; wake stays high now and goes low one edge later
    if (I_SRST)
    begin
      n          = '0;
      n.pwr      = WKR_POWER_RST;
      n.ind      = WKR_INDICATOR_RST;
      n.tst      = WKR_TEST_RST;
      n.por_pend = 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    r <= n;
  end

  // per-channel antenna selection, antenna number 1..3
  for (genvar c = 0; c < WKR_CHANNELS; c++)
  begin : g_ant
    localparam logic [1:0] ANT_M1 = 2'(c + 1);
    localparam logic [1:0] ANT_M2 = 2'(((c + 1) % 3) + 1);
    localparam logic [1:0] ANT_M3 = 2'(((c + 2) % 3) + 1);
    assign O_ANT_SEL[2*c +: 2] = (rot == WKR_ROT_MODE2) ? ANT_M2 :
                                 (rot == WKR_ROT_MODE3) ? ANT_M3 : ANT_M1;
  end

  // channel picked by the indicator select bits; the special code picks none
  assign sel_data = (sel == WKR_SEL_SPECIAL) ? 1'b0 : r.dt_s2[sel];
  assign sel_wake = (sel == WKR_SEL_SPECIAL) ? 1'b0 : r.wk_s2[sel];

  // wake pin source: combined wake or test multiplexer
  always_comb
  begin
    wake_pin_n = 1'b1;
    if (!r.tst.test_enable_bit)
    begin
      wake_pin_n = ~r.wake_act;
    end
    else
    begin
      case (tsel)
        WKR_TST_DATA:   wake_pin_n = sel_data;
        WKR_TST_CHWAKE: wake_pin_n = ~sel_wake;
        default:        wake_pin_n = 1'b1;  // unused codes idle high
      endcase
    end
  end

  assign O_WAKE_N = wake_pin_n;

  // configuration straight from the register bits
  assign O_CHAN_ON     = {r.pwr.chan3_on, r.pwr.chan2_on, r.pwr.chan1_on};
  assign O_REG_ON      = r.pwr.regulator_on;
  assign O_INPUT_SHORT = (rot == WKR_ROT_SHORT);
  assign O_DAMP_ON     = r.ind.input_damping_on;
  assign O_STEP_HIGH   = r.tst.indicator_step_high;

  // indicator pin; high impedance from the second core edge after select falls, once r.cs_s2 is low
  assign O_IND_SEL       = sel;
  assign O_BANDGAP_SEL   = (sel == WKR_SEL_SPECIAL) && !r.tst.test_enable_bit;
  assign O_IND_ANALOG_EN = r.cs_s2 && (omode == WKR_OUT_ANALOG);
  assign O_IND_OE        = r.cs_s2 && (omode == WKR_OUT_DIGITAL);
  assign O_IND_O         = (sel == WKR_SEL_SPECIAL) ? wake_pin_n :
                           (r.tst.test_enable_bit && tsel == WKR_TST_CHWAKE) ? ~sel_wake : sel_data;

  // checks
  property p_por_wake;
    @(posedge I_CLK) disable iff (I_SRST)
    r.por_pend && !r.ind.wake_release |=> r.wake_act && (r.tst.test_enable_bit || !O_WAKE_N);
  endproperty
  a_por_wake: assert property (p_por_wake) else $error("wake not raised after reset");

  property p_reset_defaults;
    @(posedge I_CLK) I_SRST |=> r.pwr == WKR_POWER_RST && r.tst == WKR_TEST_RST && O_WAKE_N;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state");

  property p_release_holds;
    @(posedge I_CLK) disable iff (I_SRST)
    r.ind.wake_release |=> !r.wake_act;
  endproperty
  a_release_holds: assert property (p_release_holds) else $error("wake not released");

  property p_chan_wake;
    @(posedge I_CLK) disable iff (I_SRST)
    (|r.wk_s2) && !r.ind.wake_release |=> r.wake_act;
  endproperty
  a_chan_wake: assert property (p_chan_wake) else $error("channel wake lost");

  property p_cs_hiz;
    @(posedge I_CLK) disable iff (I_SRST)
    !r.cs_s2 |-> !O_IND_OE && !O_IND_ANALOG_EN;
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("indicator driven while deselected");

  property p_normal_pin;
    @(posedge I_CLK) disable iff (I_SRST)
    !r.tst.test_enable_bit |-> O_WAKE_N == !r.wake_act;
  endproperty
  a_normal_pin: assert property (p_normal_pin) else $error("wake pin source wrong");

  property p_gen_cleared;
    @(posedge I_CLK) disable iff (I_SRST)
    !r.tst.periodic_wake_on |=> r.gen_cnt == '0;
  endproperty
  a_gen_cleared: assert property (p_gen_cleared) else $error("generator counter not held");

  property p_gen_wake;
    @(posedge I_CLK) disable iff (I_SRST)
    gen_hit && !r.ind.wake_release |=> r.wake_act && r.gen_cnt == '0;
  endproperty
  a_gen_wake: assert property (p_gen_wake) else $error("generator wake missing");

  property p_frame_latch;
    @(posedge I_CLK) disable iff (I_SRST)
    cs_fall && frame_addr == WKR_ADDR_POWER |=> r.pwr == $past(frame_data);
  endproperty
  a_frame_latch: assert property (p_frame_latch) else $error("frame not latched");

  property p_latch_ind;
    @(posedge I_CLK) disable iff (I_SRST)
    cs_fall && frame_addr == WKR_ADDR_INDICATOR |=> r.ind == $past(frame_data);
  endproperty
  a_latch_ind: assert property (p_latch_ind) else $error("indicator frame not latched");

  property p_latch_test;
    @(posedge I_CLK) disable iff (I_SRST)
    cs_fall && frame_addr == WKR_ADDR_TEST |=> r.tst == $past(frame_data);
  endproperty
  a_latch_test: assert property (p_latch_test) else $error("test frame not latched");

  // the correlator address belongs to a register outside this bank, so nothing here may move
  property p_corr_ignored;
    @(posedge I_CLK) disable iff (I_SRST)
    cs_fall && frame_addr == WKR_ADDR_CORR |=> $stable(r.pwr) && $stable(r.ind) && $stable(r.tst);
  endproperty
  a_corr_ignored: assert property (p_corr_ignored) else $error("foreign address changed a register");

  property p_wake_stays;
    @(posedge I_CLK) disable iff (I_SRST)
    r.wake_act && !r.ind.wake_release |=> r.wake_act;
  endproperty
  a_wake_stays: assert property (p_wake_stays) else $error("wake dropped without release");

  property p_wake_cause;
    @(posedge I_CLK) disable iff (I_SRST)
    !r.wake_act && !r.por_pend && !(|r.wk_s2) && !gen_hit |=> !r.wake_act;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake raised without a cause");

  property p_gen_count;
    @(posedge I_CLK) disable iff (I_SRST)
    r.tst.periodic_wake_on && !gen_hit |=> r.gen_cnt == $past(r.gen_cnt) + 1'b1;
  endproperty
  a_gen_count: assert property (p_gen_count) else $error("generator counter stalled");

  property p_test_data;
    @(posedge I_CLK) disable iff (I_SRST)
    r.tst.test_enable_bit && tsel == WKR_TST_DATA && sel != WKR_SEL_SPECIAL |-> O_WAKE_N == r.dt_s2[sel];
  endproperty
  a_test_data: assert property (p_test_data) else $error("test data not on wake pin");

  property p_test_chwake;
    @(posedge I_CLK) disable iff (I_SRST)
    r.tst.test_enable_bit && tsel == WKR_TST_CHWAKE && sel != WKR_SEL_SPECIAL |-> O_WAKE_N == !r.wk_s2[sel];
  endproperty
  a_test_chwake: assert property (p_test_chwake) else $error("channel wake not on wake pin");

  property p_hiz_mode;
    @(posedge I_CLK) disable iff (I_SRST)
    omode == WKR_OUT_HIZ |-> !O_IND_OE && !O_IND_ANALOG_EN;
  endproperty
  a_hiz_mode: assert property (p_hiz_mode) else $error("indicator driven in hiz mode");

  property p_reset_hiz;
    @(posedge I_CLK) I_SRST |=> !O_IND_OE && !O_IND_ANALOG_EN && r.ind == WKR_INDICATOR_RST;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("indicator not idle after reset");

endmodule

// ---- sim/wkr_host_model.sv ----
// host side model: drives the three-wire programming link
`timescale 1ns/1ps
module wkr_host_model
(
  // serial link
  output logic o_scl,
  output logic o_sda,
  output logic o_cs
);
  // link idles with select low and clock stopped
  initial
  begin
    o_scl = 1'b0;
    o_sda = 1'b0;
    o_cs  = 1'b0;
  end
  // one frame lsb first; the select lead lets the core see select high
  task automatic send(input logic [1:0] addr, input logic [5:0] data);
    logic [7:0] frame;
    if (addr == 2'h2)
      data[3] = 1'b0;
    frame = {data, addr};
    o_cs = 1'b1;
    #200;
    for (int i = 0; i < 8; i++)
    begin
      o_sda = frame[i];
      #6 o_scl = 1'b1;
      #6 o_scl = 1'b0;
    end
    o_sda = ~o_sda; // released line must not look stable
    #10 o_cs = 1'b0;
    #200; // low gap of five core cycles
  endtask
  // toggle the release bit high then low
  task automatic release_wake(input logic [5:0] ind);
    send(2'h1, ind | 6'h20);
    send(2'h1, ind & 6'h1F);
  endtask
endmodule

// ---- sim/wkr_cfg_regs_tb_top.sv ----
// self-checking bench for the wakeup receiver configuration bank
`timescale 1ns/1ps
module wkr_cfg_regs_tb_top;
  import wkr_pkg::*;
  `define CHK(g, e) chk((g) === (e), 8'(g), 8'(e))
  localparam int GEN = 50;
  logic       clk;
  logic       srst;
  logic       scl;
  logic       sda;
  logic       cs;
  logic [2:0] ch_wake;
  logic [2:0] ch_data;
  logic [2:0] chan_on;
  logic       reg_on;
  logic [5:0] ant;
  logic       short_in;
  logic       damp;
  logic       step;
  logic [1:0] ind_sel;
  logic       bg;
  logic       an_en;
  logic       ind_o;
  logic       ind_oe;
  logic       wake_n;
  logic       w1;
  int         fails;
  int         n_checks;
  int         cycles;
  logic [5:0] ant_exp [4] = '{6'h39, 6'h1E, 6'h27, 6'h39};

  wkr_host_model i_host (.o_scl(scl), .o_sda(sda), .o_cs(cs));
  wkr_cfg_regs #(.P_GEN_CYCLES(WKR_GEN_CNT_W'(GEN))) i_dut (
    .I_CLK(clk), .I_SRST(srst), .I_SCL(scl), .I_SDA(sda), .I_CS(cs),
    .I_CH_WAKE(ch_wake), .I_CH_DATA(ch_data), .O_CHAN_ON(chan_on), .O_REG_ON(reg_on),
    .O_ANT_SEL(ant), .O_INPUT_SHORT(short_in), .O_DAMP_ON(damp), .O_STEP_HIGH(step),
    .O_IND_SEL(ind_sel), .O_BANDGAP_SEL(bg), .O_IND_ANALOG_EN(an_en), .O_IND_O(ind_o),
    .O_IND_OE(ind_oe), .O_WAKE_N(wake_n));

  // 25 mhz core clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard: the whole run needs about five hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input bit ok, input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (!ok)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // frame, then back onto a falling edge so later stimulus and checks stay clear of the core edge
  task automatic snd(input logic [1:0] a, input logic [5:0] d);
    i_host.send(a, d);
    cyc(1);
  endtask
  task automatic rel();
    i_host.release_wake(6'h00);
    cyc(1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // defaults and power-on wake
  task automatic t_reset();
    cyc(4);
    `CHK(wake_n, 1'b1);
    `CHK(ind_oe, 1'b0);
    cyc(2);
    srst = 1'b0;
    cyc(2);
    `CHK({chan_on, reg_on}, 4'hF);
    `CHK({short_in, ant}, 7'h39);
    `CHK({step, damp, ind_sel}, 4'h8);
    `CHK(wake_n, 1'b0);
  endtask
  // release holds wake high, events refused until rearmed
  task automatic t_release();
    snd(2'h1, 6'h20);
    `CHK(wake_n, 1'b1);
    ch_wake = 3'h4;
    cyc(5);
    `CHK(wake_n, 1'b1);
    ch_wake = 3'h0;
    snd(2'h1, 6'h00);
    `CHK(wake_n, 1'b1);
    ch_wake = 3'h2;
    cyc(1);
    ch_wake = 3'h0;
    cyc(3);
    `CHK(wake_n, 1'b0);
    rel();
    `CHK(wake_n, 1'b1);
  endtask
  // every rotation code, plus the unmapped address
  task automatic t_power();
    for (int r = 0; r < 4; r++)
    begin
      snd(2'h0, {r[1:0], 4'h2});
      `CHK({chan_on, reg_on}, 4'h4);
      `CHK(ant, ant_exp[r]);
      `CHK(short_in, r == 3);
    end
    snd(2'h3, 6'h3F);
    `CHK(chan_on, 3'h2);
    snd(2'h0, 6'h0F);
  endtask
  // indicator pin: select, modes, chip select gating
  task automatic t_ind();
    snd(2'h1, 6'h1B);
    `CHK({damp, ind_sel, bg}, 4'hF);
    `CHK(ind_oe, 1'b0);
    fork
      i_host.send(2'h1, 6'h1B);
      begin
        cyc(5);
        `CHK({ind_oe, an_en}, 2'h2);
        `CHK(ind_o, wake_n);
      end
    join
    // the mode only takes effect when a frame ends, so load analog first and look during the next frame
    snd(2'h1, 6'h17);
    `CHK({ind_oe, an_en}, 2'h0);
    fork
      i_host.send(2'h1, 6'h17);
      begin
        cyc(5);
        `CHK({ind_oe, an_en}, 2'h1);
      end
    join
    snd(2'h2, 6'h11);
    `CHK(bg, 1'b0);
  endtask
  // test multiplexer onto the wake pin, channel two
  task automatic t_test();
    snd(2'h1, 6'h01);
    ch_data = 3'h2;
    cyc(4);
    w1 = wake_n;
    ch_data = 3'h0;
    cyc(4);
    `CHK(wake_n ^ w1, 1'b1);
    snd(2'h2, 6'h13);
    ch_wake = 3'h2;
    cyc(4);
    `CHK(wake_n, 1'b0);
    ch_wake = 3'h0;
    cyc(4);
    `CHK(wake_n, 1'b1);
    // unused select code idles high although the combined wake is pending
    snd(2'h2, 6'h15);
    `CHK(wake_n, 1'b1);
    snd(2'h2, 6'h00);
    `CHK({step, wake_n}, 2'h0);
    rel();
  endtask
  // periodic wake generator, on then off
  task automatic t_gen();
    snd(2'h2, 6'h30);
    cyc(GEN - 10);
    `CHK(wake_n, 1'b1);
    cyc(15);
    `CHK(wake_n, 1'b0);
    snd(2'h2, 6'h10);
    rel();
    cyc(2 * GEN);
    `CHK(wake_n, 1'b1);
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    ch_wake = 3'h0;
    ch_data = 3'h0;
    w1 = 1'b0;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    t_reset();
    t_release();
    t_power();
    t_ind();
    t_test();
    t_gen();
    report_and_stop();
  end
endmodule
